// ==== uab_params.svh ====
// Constants for the autobaud and wake-on-break helper
`ifndef UAB_PARAMS_SVH
`define UAB_PARAMS_SVH
`define UAB_ADDR_W 12
`define UAB_OFF_CONTROL 12'h000
`define UAB_OFF_STATUS 12'h004
`define UAB_OFF_DIVISOR 12'h008
`define UAB_OFF_RXBUF 12'h00C
`define UAB_CTL_AUTOBAUD_BIT 0
`define UAB_CTL_WAKE_BIT 1
`define UAB_CTL_WIDE_BIT 2
`define UAB_CTL_HIGH_BIT 3
`define UAB_CTL_SLEEP_BIT 4
`define UAB_CTL_SYNC_BIT 5
`define UAB_ST_OVF_BIT 0
`define UAB_ST_RCV_BIT 1
`define UAB_ST_IDLE_BIT 2
`define UAB_CONTROL_RESET 6'h00
`define UAB_DIVISOR_RESET 16'h0000
`define UAB_COUNT_START 16'h0001
`define UAB_SYNC_RISES 3'h5
`define UAB_PRESC_LL 10'h1FF
`define UAB_PRESC_MID 10'h07F
`define UAB_PRESC_HH 10'h01F
`endif

// ==== uab_pkg.sv ====
// Types for the autobaud and wake-on-break helper
package uab_pkg;
  typedef enum logic [1:0] {
    UAB_IDLE = 2'b00,
    UAB_WAIT_START = 2'b01,
    UAB_WAIT_RISE = 2'b11,
    UAB_MEASURE = 2'b10
  } uab_state_type;

  typedef struct packed {
    logic sync_mode;
    logic sleep_mode;
    logic high_speed_select;
    logic wide_divisor_select;
    logic wake_enable;
    logic autobaud_enable;
  } uab_control_type;
endpackage

// ==== uab_autobaud.sv ====
// Autobaud detect and wake-on-break helper with an APB register port
//
// Overview of operation
// - Setting autobaud enable starts calibration; normal receiver held idle meanwhile.
// - Counter starts at the first rising edge after the start bit.
// - Measures a 55h sync; ends at its fifth rising edge.
// - On completion keep count, clear autobaud enable, set receive flag.
// - Reading the receive buffer clears the receive flag; software discards it.
// - Divisor high and low form one 16-bit counter during calibration.
// - Counter clock is Fosc/512, /128, /128 or /32 by the selects.
// - Counter starts at 1; software subtracts one afterward.
// - Overflow sets the overflow flag; counting continues to the fifth edge.
// - Software clears the overflow flag by direct write.
// - Abort: clear enable first; overflow clear ignored while enable set.
// - With wake enable also set, calibrate on the character after the break.
// - While asleep the port clocks stop; no baud timing, no reception.
// - Wake-on-break works only in asynchronous mode.
// - Wake enable disables reception and watches for a falling edge.
// - Wake event sets receive flag, asynchronously when asleep; buffer read clears.
// - Rising edge ending the break clears wake enable; asleep, only if it is seen while wake_ack_q is high.
// - Non-zero character: low time to first rise counts as wake event.
`timescale 1ns/10ps
`include "uab_params.svh"
module uab_autobaud
  import uab_pkg::*;
#(
  parameter int PRESC_W = 10
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`UAB_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RECEIVE_LINE,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_DONE,
  output logic O_RX_HOLD,
  output logic O_RECEIVE_INTERRUPT_FLAG
);

  if (PRESC_W < 10) begin : g_presc_check
    $error("PRESC_W too small for the largest prescale");
  end

  // ------------------------------------------------------------
  // Receive line synchroniser and edge detect
  // ------------------------------------------------------------
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rx_meta_q <= 1'b1;
    end else begin
      rx_meta_q <= I_RECEIVE_LINE;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rx_sync_q <= 1'b1;
    end else begin
      rx_sync_q <= rx_meta_q;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_sync_q;
    end
  end
  wire logic rx_rise = rx_sync_q && !rx_prev_q;
  wire logic rx_fall = !rx_sync_q && rx_prev_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire logic apb_access = I_PSEL && I_PENABLE;
  wire logic apb_wr = apb_access && I_PWRITE;
  wire logic apb_rd = apb_access && !I_PWRITE;
  wire logic hit_ctl = I_PADDR == `UAB_OFF_CONTROL;
  wire logic hit_st = I_PADDR == `UAB_OFF_STATUS;
  wire logic hit_div = I_PADDR == `UAB_OFF_DIVISOR;
  wire logic hit_buf = I_PADDR == `UAB_OFF_RXBUF;
  wire logic hit_any = hit_ctl || hit_st || hit_div || hit_buf;
  wire logic wr_ctl = apb_wr && hit_ctl;
  wire logic wr_st = apb_wr && hit_st;
  wire logic wr_div = apb_wr && hit_div;
  wire logic rd_buf = apb_rd && hit_buf;
  wire logic rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = apb_access && !hit_any;

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  uab_control_type ctl_q;
  uab_control_type ctl_d;
  uab_state_type state_q;
  uab_state_type state_d;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic [2:0] rises_q;
  logic [2:0] rises_d;
  logic ovf_q;
  logic ovf_d;
  logic rcv_q;
  logic rcv_d;
  logic break_q;
  logic break_d;
  logic [7:0] buf_q;
  logic [7:0] buf_d;
  logic [31:0] prdata_d;

  // Async wake latch for the sleep path
  logic wake_async_q;
  logic wake_ack_meta_q;
  logic wake_ack_q;
  logic wake_done_q;

  // ------------------------------------------------------------
  // Counter clock prescale select
  // ------------------------------------------------------------
  function automatic logic [PRESC_W-1:0] presc_limit(input logic wide, input logic high);
    logic [PRESC_W-1:0] lim;
    lim = PRESC_W'(`UAB_PRESC_MID);
    if (!wide && !high) begin
      lim = PRESC_W'(`UAB_PRESC_LL);
    end else if (wide && high) begin
      lim = PRESC_W'(`UAB_PRESC_HH);
    end
    return lim;
  endfunction

  wire logic [PRESC_W-1:0] presc_top = presc_limit(ctl_q.wide_divisor_select, ctl_q.high_speed_select);
  wire logic presc_tick = presc_q == presc_top;
  wire logic running = !ctl_q.sleep_mode;
  wire logic wake_active = ctl_q.wake_enable && !ctl_q.sync_mode;
  wire logic calib_active = ctl_q.autobaud_enable && !wake_active;
  wire logic measuring = state_q == UAB_MEASURE;
  wire logic [16:0] div_inc = {1'b0, div_q} + 17'h00001;
  wire logic fifth_rise = measuring && rx_rise && rises_q == (`UAB_SYNC_RISES - 3'h1);
  wire logic ovf_clear = wr_st && !I_PWDATA[`UAB_ST_OVF_BIT] && !ctl_q.autobaud_enable;
  wire logic rx_accept = I_RX_DONE && !O_RX_HOLD;

  assign O_RX_HOLD = ctl_q.autobaud_enable || wake_active || ctl_q.sleep_mode;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    ctl_d = ctl_q;
    state_d = state_q;
    div_d = div_q;
    presc_d = presc_q;
    rises_d = rises_q;
    ovf_d = ovf_q;
    rcv_d = rcv_q;
    break_d = break_q;
    buf_d = buf_q;
    if (wr_ctl) begin
      ctl_d = uab_control_type'(I_PWDATA[5:0]);
    end
    if (wr_div) begin
      div_d = I_PWDATA[15:0];
    end
    if (ovf_clear) begin
      ovf_d = 1'b0;
    end
    if (rd_buf) begin
      rcv_d = 1'b0;
    end
    if (rx_accept) begin
      buf_d = I_RX_DATA;
      rcv_d = 1'b1;
    end
    // Wake on break
    if (wake_active && running) begin
      if (rx_fall && !break_q) begin
        break_d = 1'b1;
        rcv_d = 1'b1;
      end
      if (rx_rise && break_q) begin
        break_d = 1'b0;
        ctl_d.wake_enable = 1'b0;
      end
    end
    if (!wake_active) begin
      break_d = 1'b0;
    end
    // Sleep wake turns into a held flag
    if (wake_ack_q) begin
      rcv_d = 1'b1;
      break_d = wake_active;
    end
    if (wake_ack_q && wake_active && rx_rise) begin
      ctl_d.wake_enable = 1'b0;
    end
    // Autobaud
    if (!calib_active || !running) begin
      state_d = UAB_IDLE;
    end else begin
      unique case (state_q)
        UAB_IDLE: begin
          state_d = UAB_WAIT_START;
          rises_d = 3'h0;
        end
        UAB_WAIT_START: begin
          if (rx_fall) begin
            state_d = UAB_WAIT_RISE;
          end
        end
        UAB_WAIT_RISE: begin
          if (rx_rise) begin
            state_d = UAB_MEASURE;
            div_d = `UAB_COUNT_START;
            presc_d = '0;
            rises_d = 3'h1;
          end
        end
        UAB_MEASURE: begin
          presc_d = presc_tick ? '0 : presc_q + PRESC_W'(1);
          if (presc_tick) begin
            div_d = div_inc[15:0];
            if (div_inc[16]) begin
              ovf_d = 1'b1;
            end
          end
          if (rx_rise) begin
            rises_d = rises_q + 3'h1;
          end
          if (fifth_rise) begin
            state_d = UAB_IDLE;
            ctl_d.autobaud_enable = 1'b0;
            rcv_d = 1'b1;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Asleep wake path: falling line edge latched without clock
  // ------------------------------------------------------------
  wire logic wake_arm_n = I_RESET_N && !wake_done_q;
  always_ff @(negedge I_RECEIVE_LINE or negedge wake_arm_n) begin
    if (!wake_arm_n) begin
      wake_async_q <= 1'b0;
    end else begin
      wake_async_q <= ctl_q.sleep_mode && wake_active;
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wake_ack_meta_q <= 1'b0;
      wake_ack_q <= 1'b0;
    end else begin
      wake_ack_meta_q <= wake_async_q;
      wake_ack_q <= wake_ack_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  wire logic [31:0] st_word = {29'h0, ~(O_RX_HOLD || state_q != UAB_IDLE), rcv_q, ovf_q};
  assign prdata_d = hit_ctl ? {26'h0, ctl_q} :
                    hit_st ? st_word :
                    hit_div ? {16'h0, div_q} :
                    hit_buf ? {24'h0, buf_q} : 32'h0;

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctl_q <= uab_control_type'(`UAB_CONTROL_RESET);
    end else begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= UAB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_q <= `UAB_DIVISOR_RESET;
    end else begin
      div_q <= div_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rises_q <= 3'h0;
    end else begin
      rises_q <= rises_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rcv_q <= 1'b0;
    end else begin
      rcv_q <= rcv_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      break_q <= 1'b0;
    end else begin
      break_q <= break_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      buf_q <= 8'h00;
    end else begin
      buf_q <= buf_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PRDATA <= 32'h0;
    end else if (rd_setup) begin
      O_PRDATA <= prdata_d;
    end
  end

  // Wake latch released only once the flag is held
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wake_done_q <= 1'b0;
    end else begin
      wake_done_q <= wake_ack_q;
    end
  end

  assign O_RECEIVE_INTERRUPT_FLAG = rcv_q || wake_async_q;

endmodule // uab_autobaud

// ==== uab_autobaud_chk.sv ====
// Port assertions for the autobaud helper
`timescale 1ns/10ps
`include "uab_params.svh"
module uab_autobaud_chk
  import uab_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`UAB_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_RECEIVE_LINE,
  input wire logic I_RX_DONE,
  input wire logic O_RX_HOLD,
  input wire logic O_RECEIVE_INTERRUPT_FLAG
);
  logic line_q;
  logic [3:0] quiet_q;
  wire acc = I_PSEL && I_PENABLE;
  wire wr_ctl = acc && I_PWRITE && I_PADDR == `UAB_OFF_CONTROL;
  wire unmapped = I_PADDR[`UAB_ADDR_W-1:4] != '0 || I_PADDR[1:0] != 2'h0;
  // ----------------------------------------
  // Cycles since the line last moved
  // ----------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      line_q <= 1'b1;
      quiet_q <= 4'h0;
    end else begin
      line_q <= I_RECEIVE_LINE;
      quiet_q <= (I_RECEIVE_LINE != line_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    end
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  ready_tied_a: assert property (O_PREADY) else $error("pready low");
  err_phase_a: assert property (O_PSLVERR |-> acc) else $error("pslverr outside access");
  err_unmapped_a: assert property (acc && unmapped |-> O_PSLVERR) else $error("no pslverr on unmapped");
  unmapped_zero_a: assert property (acc && !I_PWRITE && unmapped |-> O_PRDATA == 32'h0)
    else $error("unmapped read not zero");
  prdata_hold_a: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
    else $error("prdata moved");
  hold_start_a: assert property (wr_ctl && I_PWDATA[0] |=> O_RX_HOLD) else $error("no hold");
  hold_wake_a: assert property (wr_ctl && I_PWDATA[1] && !I_PWDATA[5] |=> O_RX_HOLD)
    else $error("no hold on wake");
  hold_end_a: assert property (wr_ctl && I_PWDATA[1:0] == 2'h0 && !I_PWDATA[4] |=> !O_RX_HOLD)
    else $error("hold stuck");
  read_clear_a: assert property (acc && !I_PWRITE && I_PADDR == `UAB_OFF_RXBUF && quiet_q == 4'hF
    && !I_RX_DONE |=> !O_RECEIVE_INTERRUPT_FLAG) else $error("flag not cleared by read");
  flag_cause_a: assert property ($rose(O_RECEIVE_INTERRUPT_FLAG)
    |-> quiet_q < 4'h6 || I_RECEIVE_LINE != line_q || $past(I_RX_DONE)) else $error("flag without cause");
endmodule // uab_autobaud_chk

// ==== uab_tx_model.sv ====
// Remote serial transmitter on the receive line
`timescale 1ns/10ps
module uab_tx_model (
  input wire logic i_clock,
  output logic o_line
);
  initial o_line = 1'b1;
  task automatic level(input logic v, input int n);
    o_line <= v;
    repeat (n) @(posedge i_clock);
  endtask
  // Start bit, eight bits lsb first, stop bit
  task automatic send_byte(input logic [7:0] b, input int bp);
    level(1'b0, bp);
    for (int i = 0; i < 8; i++) begin
      level(b[i], bp);
    end
    level(1'b1, bp);
  endtask
endmodule // uab_tx_model

// ==== uab_autobaud_test.sv ====
// Self-checking bench for the autobaud helper
`timescale 1ns/10ps
`include "uab_params.svh"
bind uab_autobaud uab_autobaud_chk i_chk (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_RECEIVE_LINE(I_RECEIVE_LINE), .I_RX_DONE(I_RX_DONE),
  .O_RX_HOLD(O_RX_HOLD), .O_RECEIVE_INTERRUPT_FLAG(O_RECEIVE_INTERRUPT_FLAG));
module uab_autobaud_test;
  import uab_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rxdone = 1'b0;
  logic line;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hold;
  logic flag;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int n_tests = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  uab_tx_model i_tx (.i_clock(clk), .o_line(line));
  uab_autobaud i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_RECEIVE_LINE(line), .I_RX_DATA(8'h00), .I_RX_DONE(rxdone), .O_RX_HOLD(hold),
    .O_RECEIVE_INTERRUPT_FLAG(flag));
  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ----------------------------------------
  // APB master, one idle cycle after each transfer
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready wait", 32'h1, 32'h0);
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask
  function automatic int div_of(input logic [1:0] m);
    return (m == 2'b00) ? 512 : (m == 2'b11) ? 32 : 128;
  endfunction
  task automatic sync_check(input logic [1:0] m, input int bp);
    int e;
    e = 1 + 8 * bp / div_of(m);
    i_tx.send_byte(8'h55, bp);
    repeat (6) @(posedge clk);
    rd_chk(`UAB_OFF_STATUS, 32'h2, 32'h2, "receive flag");
    rd_chk(`UAB_OFF_CONTROL, 32'h1, 32'h0, "autobaud enable");
    apb(1'b0, `UAB_OFF_DIVISOR, 32'h0);
    chk("divisor", 32'h1, {31'h0, rd >= e - 1 && rd <= e + 1});
    chk("divisor high", 32'h0, {8'h0, rd[31:8]});
    apb(1'b0, `UAB_OFF_RXBUF, 32'h0);
    rd_chk(`UAB_OFF_STATUS, 32'h2, 32'h0, "flag after read");
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    chk("watchdog", 32'h0, 32'h1);
    tally_and_finish();
  end
  initial begin
    void'($urandom(81));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`UAB_OFF_CONTROL, 32'h3F, 32'h0, "control reset");
    rd_chk(`UAB_OFF_DIVISOR, 32'hFFFF, 32'h0, "divisor reset");
    rd_chk(`UAB_OFF_STATUS, 32'h7, 32'h4, "status reset");
    apb(1'b1, 12'h010, 32'h3F);
    chk("write error", 32'h1, {31'h0, er});
    rd_chk(12'h01C, 32'hFFFFFFFF, 32'h0, "unmapped read");
    chk("read error", 32'h1, {31'h0, er});
    rd_chk(`UAB_OFF_CONTROL, 32'h3F, 32'h0, "control untouched");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `UAB_OFF_CONTROL, {28'h0, m[0], m[1], 2'b01});
      rxdone <= 1'b1;
      @(posedge clk);
      rxdone <= 1'b0;
      rd_chk(`UAB_OFF_STATUS, 32'h6, 32'h0, "held receiver");
      sync_check(m[1:0], 64 * (1 + $urandom % 4));
    end
    rd_chk(`UAB_OFF_STATUS, 32'h4, 32'h4, "receive idle");
    apb(1'b1, `UAB_OFF_CONTROL, 32'h02);
    i_tx.level(1'b0, 416);
    chk("wake flag", 32'h1, {31'h0, flag});
    rd_chk(`UAB_OFF_CONTROL, 32'h2, 32'h2, "wake during break");
    i_tx.level(1'b1, 8);
    rd_chk(`UAB_OFF_CONTROL, 32'h2, 32'h0, "wake after break");
    apb(1'b0, `UAB_OFF_RXBUF, 32'h0);
    rd_chk(`UAB_OFF_STATUS, 32'h2, 32'h0, "wake flag read");
    apb(1'b1, `UAB_OFF_CONTROL, 32'h02);
    i_tx.send_byte(8'hF0, 32);
    rd_chk(`UAB_OFF_STATUS, 32'h2, 32'h2, "fragment wake");
    rd_chk(`UAB_OFF_CONTROL, 32'h2, 32'h0, "fragment clears wake");
    apb(1'b0, `UAB_OFF_RXBUF, 32'h0);
    apb(1'b1, `UAB_OFF_CONTROL, 32'h0F);
    i_tx.level(1'b0, 13 * 128);
    i_tx.level(1'b1, 20);
    rd_chk(`UAB_OFF_CONTROL, 32'h3, 32'h1, "calibration waits");
    apb(1'b0, `UAB_OFF_RXBUF, 32'h0);
    sync_check(2'b11, 128);
    apb(1'b1, `UAB_OFF_CONTROL, 32'h12);
    i_tx.level(1'b0, 0);
    #1;
    chk("asleep wake", 32'h1, {31'h0, flag});
    @(posedge clk);
    i_tx.level(1'b1, 20);
    chk("asleep flag held", 32'h1, {31'h0, flag});
    apb(1'b1, `UAB_OFF_CONTROL, 32'h00);
    apb(1'b0, `UAB_OFF_RXBUF, 32'h0);
    apb(1'b1, `UAB_OFF_CONTROL, 32'h22);
    i_tx.level(1'b0, 50);
    chk("sync mode wake", 32'h0, {31'h0, flag});
    i_tx.level(1'b1, 20);
    apb(1'b1, `UAB_OFF_CONTROL, 32'h01);
    apb(1'b1, `UAB_OFF_CONTROL, 32'h00);
    apb(1'b1, `UAB_OFF_STATUS, 32'h0);
    i_tx.send_byte(8'h55, 64);
    repeat (6) @(posedge clk);
    rd_chk(`UAB_OFF_STATUS, 32'h3, 32'h0, "aborted calibration");
    tally_and_finish();
  end
endmodule // uab_autobaud_test
